// File: common/pio_pkg.sv
package pio_pkg;

	// ****************************************
	// Port geometry
	// ****************************************
	localparam int PORT_W = 8;
	localparam int NPORTS = 4;
	localparam logic [7:0] LATCH_RST = 8'hff;
	localparam logic [7:0] BUS_FILL = 8'hff;

	// ****************************************
	// Machine cycle timing
	// ****************************************
	localparam int STATES_PER_CYCLE = 6;
	localparam int PHASES_PER_STATE = 2;
	localparam int SLOTS_PER_CYCLE = STATES_PER_CYCLE * PHASES_PER_STATE;
	localparam logic [3:0] SLOT_LAST = 4'hb;
	localparam logic [3:0] SLOT_PIN_UPDATE = 4'h0;
	localparam logic [3:0] SLOT_SAMPLE_P1 = 4'h8;
	localparam logic [3:0] SLOT_SAMPLE_P2 = 4'h9;
	localparam logic [3:0] SLOT_LATCH_UPDATE = 4'hb;
	localparam logic [1:0] FORCE_HIGH_CYCLES = 2'h2;

	// ****************************************
	// Alternate function bit positions
	// ****************************************
	localparam int P1_T2_CNT = 0;
	localparam int P1_T2_TRIG = 1;
	localparam int P3_RXD = 0;
	localparam int P3_TXD = 1;
	localparam int P3_INT0 = 2;
	localparam int P3_EXT_INTERRUPT_ONE_INPUT = 3;
	localparam int P3_T0 = 4;
	localparam int P3_T1 = 5;
	localparam int P3_WR = 6;
	localparam int P3_RD = 7;

	// ****************************************
	// Access types
	// ****************************************
	typedef enum logic [1:0] {
		PIO_OP_BYTE = 2'h0,
		PIO_OP_BIT = 2'h1
	} pio_op_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       rmw;
		logic [1:0] port;
		pio_op_t    op;
		logic [2:0] bit_idx;
		logic       bit_val;
		logic [7:0] wdata;
	} pio_req_t;

	typedef struct packed {
		logic        active;
		logic        wide_addr;
		logic        drive_data;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} pio_bus_t;

endpackage

// File: rtl/pio_slot_gen.sv
`timescale 1ns/100ps
`default_nettype none
module pio_slot_gen
	import pio_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Phase slot within a machine cycle
	output logic      [3:0] slot,
	output logic            phase1
);

	logic [3:0] slot_reg;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			slot_reg <= 4'h0;
		end else if (slot_reg == SLOT_LAST) begin
			slot_reg <= 4'h0;
		end else begin
			slot_reg <= slot_reg + 4'h1;
		end
	end

	assign slot = slot_reg;
	assign phase1 = ~slot_reg[0];

endmodule
`default_nettype wire

// File: rtl/pio_ports.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// (RULE1) Bus mode disconnects latches from port 0/2 drivers
// (RULE2) Bus ports unusable as general I/O
// (RULE3) Bus select from fetch pin or PC
// (RULE4) Bus keeps port 2, fills port 0 ones
// (RULE5) Port 0 drives highs on bus
// (RULE6) Wide address: port 2 strong high whole cycle
// (RULE7) Alternate function gated by latch one
// (RULE8) Reset sets all latches to one
// (RULE9) Port 1 bits 0/1 carry third timer
// (RULE10) Port 3 bits 0-5 carry serial/interrupt/timers
// (RULE11) Port 3 bits 6/7 carry write/read strobes
// (RULE12) Latch updates in final state 6 phase 2
// (RULE13) Pins follow latch at next state 1 phase 1
// (RULE14) Pin reads sample in state 5
// (RULE15) Edge reported when cycle samples differ
// (RULE16) External levels held one machine cycle
// (RULE17) Read-modify-write reads the latch
// (RULE18) Other reads return pin samples
// (RULE19) Logic, jump, inc/dec, bit ops are latch-class
// (RULE20) Bit writes rewrite whole latch byte
// (RULE21) Port 0 multiplexes low address and data
// (RULE22) Narrow address: port 2 shows register
// (RULE23) Zero-to-one gives two cycles forced high
// (RULE24) Per-access select chooses latch or pin
module pio_ports
	import pio_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	// CPU access
	input  wire pio_req_t              req,
	output logic                [7:0]  rdata,
	output logic                       slot_latch,
	output logic                       slot_sample,
	// Bus control
	input  wire logic                  external_fetch_select_pin,
	input  wire logic                  pc_external,
	input  wire logic                  xdata_access,
	input  wire logic                  wide_addr,
	input  wire logic                  drive_data,
	input  wire logic           [15:0] bus_addr,
	input  wire logic           [7:0]  bus_wdata,
	output logic                       bus_active,
	output logic                [7:0]  bus_rdata,
	// Alternate outputs from peripherals
	input  wire logic                  alt_txd,
	input  wire logic                  alt_rxd_out,
	input  wire logic                  alt_wr_strobe_b,
	input  wire logic                  alt_rd_strobe_b,
	// Alternate inputs to peripherals
	output logic                       third_timer_count_input,
	output logic                       third_timer_trigger_input,
	output logic                       alt_rxd,
	output logic                       ext_interrupt_zero_input,
	output logic                       ext_interrupt_one_input,
	output logic                       timer_zero_count_input,
	output logic                       timer_one_count_input,
	output logic                [31:0] edge_seen,
	// Pins
	input  wire logic           [31:0] pin_in,
	output logic                [31:0] pin_out,
	output logic                [31:0] pin_oe,
	output logic                [31:0] forced_high_drive_state
);

	// ****************************************
	// Slot timing
	// ****************************************
	logic [3:0] slot;
	logic       phase1;

	pio_slot_gen u_slot (
		.clk    (clk),
		.rst_b  (rst_b),
		.slot   (slot),
		.phase1 (phase1)
	);

	// Slot strobes go through one decode, except pin sampling and the edge compare, which test slot directly
	function automatic logic at_slot(input logic [3:0] s,
		input logic [3:0] want);
		return s == want;
	endfunction

	assign slot_latch = at_slot(slot, SLOT_LATCH_UPDATE); // [RULE12]
	assign slot_sample = at_slot(slot, SLOT_SAMPLE_P2); // [RULE14]

	function automatic logic [7:0] set_bit(input logic [7:0] v,
		input logic [2:0] i, input logic b);
		logic [7:0] r;
		r = v;
		r[i] = b;
		return r;
	endfunction

	// ****************************************
	// Bus select
	// ****************************************
	// External fetch pin forces all fetches outside
	assign bus_active = external_fetch_select_pin | pc_external |
		xdata_access; // [RULE3]

	// ****************************************
	// Latches
	// ****************************************
	logic [7:0] latch_reg [NPORTS];
	logic [7:0] sample_reg [NPORTS];
	logic [7:0] rmw_src;

	// Read-modify-write source is always the latch
	assign rmw_src = latch_reg[req.port]; // [RULE17] [RULE19]

	genvar gp;
	generate
		for (gp = 0; gp < NPORTS; gp++) begin : g_latch
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					latch_reg[gp] <= LATCH_RST; // [RULE8]
				end else if (gp == 0 && bus_active) begin
					latch_reg[gp] <= BUS_FILL; // [RULE4]
				end else if (gp == 2 && bus_active) begin
					latch_reg[gp] <= latch_reg[gp]; // [RULE4]
				end else if (slot_latch && req.wr &&
					req.port == gp) begin // [RULE12]
					if (req.op == PIO_OP_BIT) begin
						latch_reg[gp] <= set_bit(rmw_src,
							req.bit_idx, req.bit_val); // [RULE20]
					end else begin
						latch_reg[gp] <= req.wdata;
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// Output buffers, sampled in phase 1
	// ****************************************
	logic [7:0] obuf_reg [NPORTS];
	logic [7:0] obuf_prev [NPORTS];

	generate
		for (gp = 0; gp < NPORTS; gp++) begin : g_obuf
			// Buffers look at the latch in phase 1 only
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					obuf_reg[gp] <= LATCH_RST;
					obuf_prev[gp] <= LATCH_RST;
				end else if (phase1 &&
					at_slot(slot, SLOT_PIN_UPDATE)) begin // [RULE13]
					obuf_reg[gp] <= latch_reg[gp];
					obuf_prev[gp] <= obuf_reg[gp];
				end
			end
		end
	endgenerate

	// ****************************************
	// Forced high drive after 0 to 1
	// ****************************************
	logic [1:0] fh_cnt [32];

	genvar gb;
	generate
		for (gb = 0; gb < 32; gb++) begin : g_fh
			logic rise;

			// Port 0 has no pullup, so it never boosts
			assign rise = (gb >= 8) && obuf_reg[gb/8][gb%8] &&
				!obuf_prev[gb/8][gb%8];

			// Ticks once per machine cycle from the boost start
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					fh_cnt[gb] <= 2'h0;
				end else if (at_slot(slot, SLOT_PIN_UPDATE + 4'h1) &&
					rise) begin
					fh_cnt[gb] <= FORCE_HIGH_CYCLES; // [RULE23]
				end else if (fh_cnt[gb] != 2'h0 &&
					at_slot(slot, SLOT_PIN_UPDATE + 4'h1)) begin
					fh_cnt[gb] <= fh_cnt[gb] - 2'h1;
				end
			end
		end
	endgenerate

	// ****************************************
	// Alternate outputs into port 3 data
	// ****************************************
	logic [7:0] p3_alt;
	logic [7:0] p1_eff;
	logic [7:0] p3_eff;

	always_comb begin
		p3_alt = 8'hff;
		p3_alt[P3_RXD] = alt_rxd_out; // [RULE10]
		p3_alt[P3_TXD] = alt_txd; // [RULE10]
		p3_alt[P3_WR] = alt_wr_strobe_b; // [RULE11]
		p3_alt[P3_RD] = alt_rd_strobe_b; // [RULE11]
	end

	// A zero latch pulls the pin low whatever the peripheral wants
	assign p1_eff = obuf_reg[1];
	assign p3_eff = obuf_reg[3] & p3_alt; // [RULE7]

	// ****************************************
	// Pin drive
	// ****************************************
	logic [7:0] p0_bus;
	logic [7:0] p2_bus;
	logic [7:0] p0_drv;
	logic [7:0] p2_drv;

	// Address phase, then data when writing
	assign p0_bus = drive_data ? bus_wdata : bus_addr[7:0]; // [RULE21]
	assign p2_bus = wide_addr ? bus_addr[15:8] : obuf_reg[2]; // [RULE22]
	assign p0_drv = bus_active ? p0_bus : obuf_reg[0]; // [RULE1] [RULE2]
	assign p2_drv = bus_active ? p2_bus : obuf_reg[2]; // [RULE1] [RULE2]

	always_comb begin
		pin_out = {p3_eff, p2_drv, p1_eff, p0_drv};
		// Port 0 is open drain unless acting as a bus
		if (bus_active && (drive_data || !xdata_access)) begin
			pin_oe[7:0] = 8'hff; // [RULE5]
		end else if (bus_active) begin
			pin_oe[7:0] = 8'h00;
		end else begin
			pin_oe[7:0] = ~obuf_reg[0];
		end
		pin_oe[15:8] = ~p1_eff;
		pin_oe[23:16] = ~p2_drv;
		pin_oe[31:24] = ~p3_eff;
		if (bus_active && wide_addr) begin
			pin_oe[23:16] = 8'hff; // [RULE6]
		end
	end

	// ****************************************
	// Strong high drive
	// ****************************************
	always_comb begin
		forced_high_drive_state = 32'h0;
		for (int i = 8; i < 32; i++) begin
			forced_high_drive_state[i] = (fh_cnt[i] != 2'h0); // [RULE23]
		end
		// Whole bus cycle, not just after a rising latch bit
		if (bus_active && wide_addr) begin
			forced_high_drive_state[23:16] = p2_drv; // [RULE6]
		end
	end

	// ****************************************
	// Pin sampling in state 5
	// ****************************************
	generate
		for (gp = 0; gp < NPORTS; gp++) begin : g_samp
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					sample_reg[gp] <= LATCH_RST;
				end else if ((gp == 3 && slot == SLOT_SAMPLE_P1) ||
					(gp != 3 && slot == SLOT_SAMPLE_P2)) begin
					sample_reg[gp] <= pin_in[gp*8 +: 8]; // [RULE14]
				end
			end
		end
	endgenerate

	logic [31:0] prev_reg;
	logic [31:0] cur_all;

	assign cur_all = {sample_reg[3], sample_reg[2], sample_reg[1],
		sample_reg[0]};

	// Relies on inputs held a full machine cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_reg <= 32'hffffffff;
			edge_seen <= 32'h0;
		end else if (slot == SLOT_LAST) begin
			prev_reg <= cur_all;
			edge_seen <= prev_reg ^ cur_all; // [RULE15] [RULE16]
		end else begin
			edge_seen <= 32'h0;
		end
	end

	// ****************************************
	// Alternate inputs, gated by latch
	// ****************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			third_timer_count_input <= 1'b1;
			third_timer_trigger_input <= 1'b1;
			alt_rxd <= 1'b1;
			ext_interrupt_zero_input <= 1'b1;
			ext_interrupt_one_input <= 1'b1;
			timer_zero_count_input <= 1'b1;
			timer_one_count_input <= 1'b1;
		end else begin
			third_timer_count_input <= sample_reg[1][P1_T2_CNT] &
				latch_reg[1][P1_T2_CNT]; // [RULE9] [RULE7]
			third_timer_trigger_input <= sample_reg[1][P1_T2_TRIG] &
				latch_reg[1][P1_T2_TRIG]; // [RULE9]
			alt_rxd <= sample_reg[3][P3_RXD] &
				latch_reg[3][P3_RXD]; // [RULE10]
			ext_interrupt_zero_input <= sample_reg[3][P3_INT0] &
				latch_reg[3][P3_INT0]; // [RULE10]
			ext_interrupt_one_input <= sample_reg[3][P3_EXT_INTERRUPT_ONE_INPUT] &
				latch_reg[3][P3_EXT_INTERRUPT_ONE_INPUT]; // [RULE10]
			timer_zero_count_input <= sample_reg[3][P3_T0] &
				latch_reg[3][P3_T0]; // [RULE10]
			timer_one_count_input <= sample_reg[3][P3_T1] &
				latch_reg[3][P3_T1]; // [RULE10]
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			rdata <= req.rmw ? rmw_src :
				sample_reg[req.port]; // [RULE24] [RULE18]
		end
	end

	// ****************************************
	// Bus data in
	// ****************************************
	// Taken late in the cycle, once port 0 has turned to data
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_rdata <= 8'h00;
		end else if (at_slot(slot, SLOT_SAMPLE_P2) && bus_active) begin
			bus_rdata <= pin_in[7:0]; // [RULE21]
		end
	end

endmodule
`default_nettype wire

// File: bench/pio_ports_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module pio_ports_asserts
	import pio_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_b,
	// CPU side
	input wire pio_req_t    req,
	input wire logic [7:0]  rdata,
	input wire logic        slot_latch,
	input wire logic        slot_sample,
	// Bus control
	input wire logic        external_fetch_select_pin,
	input wire logic        pc_external,
	input wire logic        xdata_access,
	input wire logic        drive_data,
	input wire logic        bus_active,
	// Pins
	input wire logic [31:0] edge_seen,
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_oe,
	input wire logic [31:0] forced_high_drive_state
);
	// ****
	// Settling of bus mode
	// ****
	logic [1:0] mode_reg;
	logic [3:0] settle_reg;
	// Output buffers follow only at slot 0, so wait out a machine cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_reg <= 2'h0;
			settle_reg <= 4'h0;
		end else begin
			mode_reg <= {bus_active, drive_data};
			if (mode_reg != {bus_active, drive_data})
				settle_reg <= 4'h0;
			else if (settle_reg != 4'hf)
				settle_reg <= settle_reg + 4'h1;
		end
	end
	// ****
	// Properties
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_sample_to_latch;
		slot_sample ##2 slot_latch;
	endsequence
	sequence s_next_latch;
		slot_latch ##12 slot_latch;
	endsequence
	slot_order_a: assert property (slot_sample |-> s_sample_to_latch)
		else $error("latch slot not two after sample slot");
	slot_period_a: assert property (slot_latch |-> s_next_latch)
		else $error("latch slot not every twelve clocks");
	bus_select_a: assert property (bus_active == (external_fetch_select_pin || pc_external || xdata_access))
		else $error("bus select mismatch");
	edge_slot_a: assert property (|edge_seen |-> $past(slot_latch))
		else $error("edge outside slot 0");
	edge_pulse_a: assert property (|edge_seen |=> !(|edge_seen))
		else $error("edge longer than one clock");
	p0_force_a: assert property (forced_high_drive_state[7:0] == 8'h00)
		else $error("port 0 forced high");
	p0_drive_a: assert property (settle_reg == 4'hf && bus_active && drive_data |-> pin_oe[7:0] == 8'hff)
		else $error("port 0 not driven on bus");
	p0_open_a: assert property (settle_reg == 4'hf && !bus_active |-> (pin_oe[7:0] & pin_out[7:0]) == 8'h00)
		else $error("port 0 drives high as port");
	rdata_hold_a: assert property (!$past(req.rd) |-> $stable(rdata))
		else $error("read data changed without read");
endmodule
`default_nettype wire

// File: bench/pio_ext_model.sv
`timescale 1ns/100ps
`default_nettype none
module pio_ext_model (
	// Clock
	input wire logic        clk,
	// Device drive
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_oe,
	// External drive
	input wire logic [31:0] ext_en,
	input wire logic [31:0] ext_val,
	// Wire level
	output logic     [31:0] pin_in
);
	// ****
	// Wire resolution
	// ****
	// Floating port 0 toggles so no stale value passes for data
	logic float_reg = 1'b0;
	always_ff @(posedge clk)
		float_reg <= !float_reg;
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			if (pin_oe[i] && !pin_out[i])
				pin_in[i] = 1'b0;
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else
				pin_in[i] = (i < 8) ? float_reg : 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import pio_pkg::*;
	// ****
	// Signals
	// ****
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	pio_req_t    req = '0;
	logic        external_fetch_select_pin = 1'b0, pc_external = 1'b0;
	logic        xdata_access = 1'b0, wide_addr = 1'b0, drive_data = 1'b0;
	logic        alt_txd = 1'b1, alt_rxd_out = 1'b1;
	logic        alt_wr_strobe_b = 1'b1, alt_rd_strobe_b = 1'b1;
	logic [15:0] bus_addr = 16'h0000;
	logic [7:0]  bus_wdata = 8'h00;
	logic [31:0] ext_en = 32'h0, ext_val = 32'h0;
	logic [7:0]  rdata, bus_rdata, d;
	logic        slot_latch, slot_sample, bus_active, alt_rxd;
	logic        third_timer_count_input, third_timer_trigger_input;
	logic        ext_interrupt_zero_input, ext_interrupt_one_input;
	logic        timer_zero_count_input, timer_one_count_input;
	logic [31:0] edge_seen, pin_in, pin_out, pin_oe, forced_high_drive_state;
	int          failures = 0;
	int          comparisons = 0;
	always #25 clk = !clk;
	pio_ports pio_ports_i (.clk, .rst_b, .req, .rdata, .slot_latch,
		.slot_sample, .external_fetch_select_pin, .pc_external,
		.xdata_access, .wide_addr, .drive_data, .bus_addr, .bus_wdata,
		.bus_active, .bus_rdata, .alt_txd, .alt_rxd_out, .alt_wr_strobe_b,
		.alt_rd_strobe_b, .third_timer_count_input,
		.third_timer_trigger_input, .alt_rxd, .ext_interrupt_zero_input,
		.ext_interrupt_one_input, .timer_zero_count_input,
		.timer_one_count_input, .edge_seen, .pin_in, .pin_out, .pin_oe,
		.forced_high_drive_state);
	pio_ext_model pio_ext_model_i (.clk, .pin_out, .pin_oe, .ext_en,
		.ext_val, .pin_in);
	// ****
	// Shared tasks
	// ****
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic to_slot9;
		int k;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (slot_sample !== 1'b1 && k < 30);
		if (k == 30) begin
			failures++;
			stop_test;
		end
	endtask
	// Write is held from slot 10 through the slot 11 edge
	task automatic wr(logic [1:0] p, pio_op_t op, logic [2:0] i, logic b,
		logic [7:0] v);
		to_slot9;
		@(posedge clk);
		req <= '{1'b1, 1'b0, 1'b0, p, op, i, b, v};
		cyc(2);
		req.wr <= 1'b0;
	endtask
	task automatic rd(logic [1:0] p, logic m, output logic [7:0] q);
		@(posedge clk);
		req <= '{1'b0, 1'b1, m, p, PIO_OP_BYTE, 3'h0, 1'b0, 8'h00};
		@(posedge clk);
		req.rd <= 1'b0;
		@(negedge clk);
		q = rdata;
	endtask
	task automatic cnt(logic f, int b, int n, output int c);
		c = 0;
		repeat (n) begin
			@(negedge clk);
			c += f ? forced_high_drive_state[b] : edge_seen[b];
		end
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reset;
		for (int p = 0; p < 4; p++) begin
			rd(p[1:0], 1'b1, d);
			chk("latch reset", LATCH_RST, d);
		end
		$display("t_reset done");
	endtask
	task automatic t_write;
		int c;
		wr(2'h1, PIO_OP_BYTE, 3'h0, 1'b0, 8'h00);
		@(negedge clk);
		chk("pin before slot 0", 8'hff, pin_in[15:8]);
		@(negedge clk);
		chk("pin after slot 0", 8'h00, pin_in[15:8]);
		rd(2'h1, 1'b1, d);
		chk("latch", 8'h00, d);
		wr(2'h1, PIO_OP_BYTE, 3'h0, 1'b0, 8'hff);
		cnt(1'b1, 8, 40, c);
		chk("forced clocks", 2 * SLOTS_PER_CYCLE, c);
		$display("t_write done");
	endtask
	task automatic t_bit;
		wr(2'h1, PIO_OP_BIT, 3'h3, 1'b0, 8'h00);
		ext_en <= 32'h0000_0200;
		cyc(24);
		rd(2'h1, 1'b0, d);
		chk("pin read", 8'hf5, d);
		rd(2'h1, 1'b1, d);
		chk("bit write latch", 8'hf7, d);
		chk("timer2 count", 1, third_timer_count_input);
		chk("timer2 trigger", 0, third_timer_trigger_input);
		@(posedge clk);
		ext_en <= 32'h0;
		$display("t_bit done");
	endtask
	task automatic t_alt;
		int c;
		@(posedge clk);
		ext_en <= 32'h3d00_0000;
		alt_txd <= 1'b0;
		alt_wr_strobe_b <= 1'b0;
		cnt(1'b0, 29, 30, c);
		chk("falling edge", 1, c);
		chk("timer1 input", 0, timer_one_count_input);
		chk("rx input", 0, alt_rxd);
		chk("int0 input", 0, ext_interrupt_zero_input);
		chk("ext_interrupt_one_input input", 0, ext_interrupt_one_input);
		chk("timer0 input", 0, timer_zero_count_input);
		chk("tx pin", 0, pin_in[25]);
		chk("write strobe pin", 0, pin_in[30]);
		@(posedge clk);
		ext_en <= 32'h0;
		alt_txd <= 1'b1;
		alt_wr_strobe_b <= 1'b1;
		cnt(1'b0, 29, 30, c);
		chk("rising edge", 1, c);
		wr(2'h3, PIO_OP_BIT, 3'h5, 1'b0, 8'h00);
		cyc(24);
		chk("gated timer1", 0, timer_one_count_input);
		chk("gated pin", 0, pin_in[29]);
		wr(2'h3, PIO_OP_BIT, 3'h5, 1'b1, 8'h00);
		$display("t_alt done");
	endtask
	task automatic t_bus;
		wr(2'h0, PIO_OP_BYTE, 3'h0, 1'b0, 8'h00);
		wr(2'h2, PIO_OP_BYTE, 3'h0, 1'b0, 8'h33);
		for (int s = 0; s < 3; s++) begin
			@(posedge clk);
			{external_fetch_select_pin, pc_external, xdata_access} <= 3'h1 << s;
			@(negedge clk);
			chk("bus select", 1, bus_active);
		end
		@(posedge clk);
		wide_addr <= 1'b1;
		drive_data <= 1'b1;
		bus_addr <= 16'h5aa5;
		bus_wdata <= 8'h3c;
		cyc(24);
		chk("port 2 address", 8'h5a, pin_in[23:16]);
		chk("port 0 data", 8'h3c, pin_in[7:0]);
		chk("bus data in", 8'h3c, bus_rdata);
		chk("port 2 strong", 8'h5a, forced_high_drive_state[23:16]);
		wr(2'h0, PIO_OP_BYTE, 3'h0, 1'b0, 8'h00);
		wr(2'h2, PIO_OP_BYTE, 3'h0, 1'b0, 8'h11);
		rd(2'h0, 1'b1, d);
		chk("port 0 fill", BUS_FILL, d);
		@(posedge clk);
		wide_addr <= 1'b0;
		drive_data <= 1'b0;
		xdata_access <= 1'b1;
		ext_en <= 32'h0000_00ff;
		ext_val <= 32'h0000_0096;
		cyc(24);
		chk("port 2 narrow", 8'h33, pin_in[23:16]);
		chk("bus read float", 8'h96, bus_rdata);
		rd(2'h2, 1'b1, d);
		chk("port 2 kept", 8'h33, d);
		xdata_access <= 1'b0;
		$display("t_bus done");
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		cyc(12);
		rst_b <= 1'b1;
		t_reset;
		t_write;
		t_bit;
		t_alt;
		t_bus;
		stop_test;
	end
endmodule
bind pio_ports pio_ports_asserts pio_ports_asserts_i (.clk, .rst_b, .req,
	.rdata, .slot_latch, .slot_sample, .external_fetch_select_pin,
	.pc_external, .xdata_access, .drive_data, .bus_active, .edge_seen,
	.pin_out, .pin_oe, .forced_high_drive_state);
`default_nettype wire
